// >>> core/tcc_sync.sv
`timescale 1ns/1ps
module tcc_sync
  import tcc_pkg::*;
(
  input  wire logic      clk_sys_i,
  input  wire logic      reset_i,
  input  wire tcc_pins_t pins_i,
  output tcc_pins_t      sync_o,
  output tcc_pins_t      prev_o
);
  tcc_pins_t meta;

  // ----------------------------------------------------------------
  // two-stage sync plus edge history
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      meta   <= '0;
      sync_o <= '0;
      prev_o <= '0;
    end else begin
      meta   <= pins_i;
      sync_o <= meta;
      prev_o <= sync_o;
    end
  end
endmodule

// >>> core/tcc_timer.sv
`timescale 1ns/1ps
// Notes on behaviour
// - one 16-bit counter, four capture/compare channels
// - each channel independently compare or capture
// - count off, or cpu clock over 12/24
// - gated mode counts only while pin high
// - external mode counts pin rising edges
// - wrap to zero sets overflow flag
// - overflow reload loads reload/capture value
// - reload pin falling edge loads counter
// - pin reload flag needs both enables
// - compare channels drive their own pins
// - direct or indirect compare output method
// - direct: low below, high at/above
// - equality sets channel compare flag
// - indirect: take latch level at match
// - indirect: overflow leaves pins alone
// - capture pin edges copy counter
// - low-byte write captures counter instead
// - reload select codes 00/01 off
// - two-bit function code per channel
// - method bit 0 direct, 1 indirect
module tcc_timer
  import tcc_pkg::*;
(
  input  wire logic        clk_sys_i,
  input  wire logic        reset_i,
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hready_i,
  output logic      [31:0] hrdata_o,
  output logic             hreadyout_o,
  output logic             hresp_o,
  input  wire tcc_pins_t   pins_i,
  output logic      [3:0]  compare_out_o,
  output logic             irq_request_o
);
  logic [7:0]  control;
  logic [7:0]  module_function;
  logic [15:0] counter;
  logic [15:0] cc_reg [NUM_CH];
  logic [5:0]  irq_enable;
  logic [5:0]  flags;
  logic [3:0]  port_latch;
  logic [4:0]  prescale_cnt;
  logic        wr_pending;
  logic [7:0]  wr_addr;
  tcc_pins_t   pin_s;
  tcc_pins_t   pin_p;

  logic        tick;
  logic        overflow;
  logic        pin_reload;
  logic        wr_en;
  logic [15:0] next_counter;
  logic [3:0]  match;
  logic [3:0]  cap_pin_evt;

  function automatic logic [1:0] fn_of(input logic [7:0] f, input int ch);
    fn_of = f[2*ch +: 2];
  endfunction

  function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
    hit = (a == b);
  endfunction

  tcc_sync u_sync (
    .clk_sys_i (clk_sys_i),
    .reset_i   (reset_i),
    .pins_i    (pins_i),
    .sync_o    (pin_s),
    .prev_o    (pin_p)
  );

  // ----------------------------------------------------------------
  // ahb-lite slave, zero wait state
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      wr_pending <= 1'b0;
      wr_addr    <= 8'h00;
    end else if (hready_i) begin
      wr_pending <= hsel_i && htrans_i[1] && hwrite_i;
      wr_addr    <= haddr_i[7:0];
    end
  end

  assign wr_en = wr_pending;

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      hrdata_o    <= ZERO_WORD;
      hreadyout_o <= 1'b1;
      hresp_o     <= 1'b0;
    end else begin
      hreadyout_o <= 1'b1;
      hresp_o     <= 1'b0;
      if (hready_i && hsel_i && htrans_i[1] && !hwrite_i) begin
        case (haddr_i[7:0])
          ADDR_CONTROL:    hrdata_o <= {24'h000000, control};
          ADDR_FUNCTION:   hrdata_o <= {24'h000000, module_function};
          ADDR_COUNTER:    hrdata_o <= {16'h0000, counter};
          ADDR_RELOAD_CAP: hrdata_o <= {16'h0000, cc_reg[0]};
          ADDR_CMP_CAP_1:  hrdata_o <= {16'h0000, cc_reg[1]};
          ADDR_CMP_CAP_2:  hrdata_o <= {16'h0000, cc_reg[2]};
          ADDR_CMP_CAP_3:  hrdata_o <= {16'h0000, cc_reg[3]};
          ADDR_IRQ_ENABLE: hrdata_o <= {26'h0000000, irq_enable};
          ADDR_FLAGS:      hrdata_o <= {26'h0000000, flags};
          ADDR_PORT_LATCH: hrdata_o <= {28'h0000000, port_latch};
          default:         hrdata_o <= ZERO_WORD;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      control         <= 8'h00;
      module_function <= 8'h00;
      irq_enable      <= 6'h00;
      port_latch      <= 4'h0;
    end else if (wr_en) begin
      if (hit(wr_addr, ADDR_CONTROL))    control <= hwdata_i[7:0];
      if (hit(wr_addr, ADDR_FUNCTION))   module_function <= hwdata_i[7:0];
      if (hit(wr_addr, ADDR_IRQ_ENABLE)) irq_enable <= hwdata_i[5:0];
      if (hit(wr_addr, ADDR_PORT_LATCH)) port_latch <= hwdata_i[3:0];
    end
  end

  // ----------------------------------------------------------------
  // count tick generation
  // ----------------------------------------------------------------
  logic [1:0] count_control;
  logic       prescale_done;
  assign count_control = control[CTL_COUNT_LSB +: 2];
  assign prescale_done = (prescale_cnt == (control[CTL_PRESCALE_BIT] ? DIV_24 : DIV_12));

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      prescale_cnt <= 5'h00;
    end else if (count_control == COUNT_OFF || count_control == COUNT_EXT || prescale_done) begin
      prescale_cnt <= 5'h00;
    end else if (count_control == COUNT_INT || pin_s.ext_count_pin) begin
      prescale_cnt <= prescale_cnt + 5'h01;
    end
  end

  always_comb begin
    case (count_control)
      COUNT_INT:   tick = prescale_done;
      COUNT_GATED: tick = prescale_done && pin_s.ext_count_pin;
      COUNT_EXT:   tick = pin_s.ext_count_pin && !pin_p.ext_count_pin;
      default:     tick = 1'b0;
    endcase
  end

  assign overflow   = tick && (counter == CNT_MAX);
  assign pin_reload = (control[CTL_RELOAD_LSB +: 2] == RELOAD_PIN)
                      && pin_p.ext_reload_pin && !pin_s.ext_reload_pin;

  // ----------------------------------------------------------------
  // counter
  // ----------------------------------------------------------------
  always_comb begin
    next_counter = counter;
    if (wr_en && hit(wr_addr, ADDR_COUNTER)) next_counter = hwdata_i[15:0];
    if (tick) next_counter = counter + 16'h0001;
    if (overflow && control[CTL_RELOAD_LSB +: 2] == RELOAD_OVF)
      next_counter = cc_reg[0];
    if (pin_reload) next_counter = cc_reg[0];
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) counter <= CNT_RESET;
    else counter <= next_counter;
  end

  // ----------------------------------------------------------------
  // capture/compare registers
  // ----------------------------------------------------------------
  logic [7:0] ch_addr [NUM_CH];
  assign ch_addr[0] = ADDR_RELOAD_CAP;
  assign ch_addr[1] = ADDR_CMP_CAP_1;
  assign ch_addr[2] = ADDR_CMP_CAP_2;
  assign ch_addr[3] = ADDR_CMP_CAP_3;

  logic sw_low_write;
  assign sw_low_write = wr_en && hit(wr_addr, ADDR_CAP_LOW_TRIG);

  always_comb begin
    for (int i = 0; i < NUM_CH; i++) begin
      match[i]       = (fn_of(module_function, i) == FN_COMPARE) && (counter == cc_reg[i]);
      cap_pin_evt[i] = (fn_of(module_function, i) == FN_CAP_PIN)
                       && pin_s.capture_pin[i] && !pin_p.capture_pin[i];
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      for (int i = 0; i < NUM_CH; i++) cc_reg[i] <= CNT_RESET;
    end else begin
      for (int i = 0; i < NUM_CH; i++) begin
        if (cap_pin_evt[i]) begin
          cc_reg[i] <= counter;
        end else if (sw_low_write && hwdata_i[i] && fn_of(module_function, i) == FN_CAP_SW) begin
          cc_reg[i] <= counter;
        end else if (wr_en && hit(wr_addr, ch_addr[i])) begin
          cc_reg[i] <= hwdata_i[15:0];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // compare outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      compare_out_o <= 4'h0;
    end else begin
      for (int i = 0; i < NUM_CH; i++) begin
        if (fn_of(module_function, i) == FN_COMPARE) begin
          if (!control[CTL_METHOD_BIT]) begin
            compare_out_o[i] <= (counter >= cc_reg[i]);
          end else if (match[i]) begin
            compare_out_o[i] <= port_latch[i];
          end
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // flags and interrupt request
  // ----------------------------------------------------------------
  logic [5:0] set_flags;
  assign set_flags = {pin_reload && irq_enable[IEN_EXTRL_BIT] && irq_enable[IEN_TIMER_BIT],
                      overflow, match};

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      flags <= 6'h00;
    end else if (wr_en && hit(wr_addr, ADDR_FLAGS)) begin
      flags <= hwdata_i[5:0] | set_flags;
    end else begin
      flags <= flags | set_flags;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) irq_request_o <= 1'b0;
    else irq_request_o <= irq_enable[IEN_TIMER_BIT]
                         && ((flags[FLG_OVF_BIT]) || flags[FLG_EXTRL_BIT]
                         || |(flags[FLG_CMP_LSB +: 4] & irq_enable[IEN_CMP_LSB +: 4]));
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_ovf_flag;
    @(posedge clk_sys_i) disable iff (reset_i) overflow |=> flags[FLG_OVF_BIT];
  endproperty
  a_ovf_flag: assert property (p_ovf_flag) else $error("overflow flag not set");

  property p_ovf_reload;
    @(posedge clk_sys_i) disable iff (reset_i)
      overflow && control[CTL_RELOAD_LSB +: 2] == RELOAD_OVF && !pin_reload |=> counter == $past(cc_reg[0]);
  endproperty
  a_ovf_reload: assert property (p_ovf_reload) else $error("overflow reload wrong");

  property p_pin_reload;
    @(posedge clk_sys_i) disable iff (reset_i) pin_reload |=> counter == $past(cc_reg[0]);
  endproperty
  a_pin_reload: assert property (p_pin_reload) else $error("pin reload wrong");

  property p_stopped;
    @(posedge clk_sys_i) disable iff (reset_i)
      count_control == COUNT_OFF && !wr_en && !pin_reload |=> $stable(counter);
  endproperty
  a_stopped: assert property (p_stopped) else $error("counter moved when off");

  property p_gate;
    @(posedge clk_sys_i) disable iff (reset_i) count_control == COUNT_GATED && !pin_s.ext_count_pin |-> !tick;
  endproperty
  a_gate: assert property (p_gate) else $error("gated tick while low");

  sequence s_ext_edge;
    count_control == COUNT_EXT && !pin_p.ext_count_pin ##0 pin_s.ext_count_pin;
  endsequence
  property p_ext;
    @(posedge clk_sys_i) disable iff (reset_i) s_ext_edge |-> tick;
  endproperty
  a_ext: assert property (p_ext) else $error("ext edge missed");

  property p_direct;
    @(posedge clk_sys_i) disable iff (reset_i)
      fn_of(module_function, 1) == FN_COMPARE && !control[CTL_METHOD_BIT]
      |=> compare_out_o[1] == ($past(counter) >= $past(cc_reg[1]));
  endproperty
  a_direct: assert property (p_direct) else $error("direct output wrong");

  property p_cmp_flag;
    @(posedge clk_sys_i) disable iff (reset_i) match[1] |=> flags[FLG_CMP_LSB + 1];
  endproperty
  a_cmp_flag: assert property (p_cmp_flag) else $error("compare flag not set");

  property p_indirect_hold;
    @(posedge clk_sys_i) disable iff (reset_i)
      control[CTL_METHOD_BIT] && !match[1] |=> $stable(compare_out_o[1]);
  endproperty
  a_indirect_hold: assert property (p_indirect_hold) else $error("indirect output changed");

  property p_cap_pin;
    @(posedge clk_sys_i) disable iff (reset_i) cap_pin_evt[2] |=> cc_reg[2] == $past(counter);
  endproperty
  a_cap_pin: assert property (p_cap_pin) else $error("pin capture wrong");
endmodule

// >>> dv/tb_tcc_timer.sv
`timescale 1ns/1ps
module tb_tcc_timer
  import tcc_pkg::*;
;
  logic        clk_sys_i = 1'b0;
  logic        reset_i;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hready;
  logic        hresp;
  logic [3:0]  cmp_out;
  logic        irq;
  tcc_pins_t   pins;
  int          error_cnt = 0;
  int          cmp_count = 0;
  int          cyc = 0;

  always #12.5 clk_sys_i = ~clk_sys_i;

  tcc_pin_model pm (
    .clk_sys_i (clk_sys_i),
    .pins_o    (pins)
  );

  tcc_timer dut_u (
    .clk_sys_i     (clk_sys_i),
    .reset_i       (reset_i),
    .hsel_i        (hsel),
    .haddr_i       (haddr),
    .htrans_i      (htrans),
    .hwrite_i      (hwrite),
    .hsize_i       (hsize),
    .hwdata_i      (hwdata),
    .hready_i      (hready),
    .hrdata_o      (hrdata),
    .hreadyout_o   (hready),
    .hresp_o       (hresp),
    .pins_i        (pins),
    .compare_out_o (cmp_out),
    .irq_request_o (irq)
  );

  // ----
  // helpers
  // ----
  task automatic complete_run();
    $display("checks %0d errors %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      complete_run();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask

  function automatic logic [31:0] ctl(logic [1:0] c, logic [1:0] r, logic m);
    ctl = ZERO_WORD;
    ctl[CTL_COUNT_LSB+:2] = c;
    ctl[CTL_METHOD_BIT] = m;
    ctl[CTL_RELOAD_LSB+:2] = r;
  endfunction

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge clk_sys_i); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk_sys_i); while (hready !== 1'b1);
    q = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    bus(1'b0, a, ZERO_WORD, q);
  endtask

  // counter advance over exactly 240 cycles
  task automatic span(output logic [31:0] d);
    logic [31:0] a;
    logic [31:0] b;
    rd(ADDR_COUNTER, a);
    repeat (238) @(posedge clk_sys_i);
    rd(ADDR_COUNTER, b);
    d = {16'h0, b[15:0] - a[15:0]};
  endtask

  // ----
  // scenarios
  // ----
  task automatic t_reset();
    logic [31:0] q;
    rd(ADDR_COUNTER, q);
    chk(q, ZERO_WORD);
    rd(ADDR_FLAGS, q);
    chk(q, ZERO_WORD);
    rd(8'h3c, q);
    chk(q, ZERO_WORD);
    chk({31'h0, hresp}, ZERO_WORD);
    chk({28'h0, cmp_out}, ZERO_WORD);
  endtask

  task automatic t_rate();
    logic [31:0] d;
    logic [31:0] w;
    for (int p = 0; p < 3; p++) begin
      w = ctl(p == 2 ? COUNT_OFF : COUNT_INT, 2'h0, 1'b0);
      w[CTL_PRESCALE_BIT] = p[0];
      wr(ADDR_COUNTER, ZERO_WORD);
      wr(ADDR_CONTROL, w);
      span(d);
      chk(d, p == 0 ? 32'h14 : (p == 1 ? 32'ha : ZERO_WORD));
    end
  endtask

  task automatic t_gate();
    logic [31:0] d;
    wr(ADDR_CONTROL, ctl(COUNT_GATED, 2'h0, 1'b0));
    span(d);
    chk(d, ZERO_WORD);
    pm.set_count(1'b1);
    span(d);
    chk(d, 32'h14);
    pm.set_count(1'b0);
  endtask

  task automatic t_ovf();
    logic [31:0] q;
    wr(ADDR_RELOAD_CAP, 32'h1234);
    for (int r = 0; r < 3; r++) begin
      wr(ADDR_CONTROL, ctl(COUNT_EXT, r[1:0], 1'b0));
      wr(ADDR_COUNTER, 32'hffff);
      pm.count_pulse();
      rd(ADDR_COUNTER, q);
      chk(q, r == 2 ? 32'h1234 : ZERO_WORD);
    end
    rd(ADDR_FLAGS, q);
    chk(q, 32'h10);
    wr(ADDR_FLAGS, ZERO_WORD);
  endtask

  task automatic t_pinrl();
    logic [31:0] q;
    wr(ADDR_RELOAD_CAP, 32'h0abc);
    wr(ADDR_CONTROL, ctl(COUNT_OFF, RELOAD_PIN, 1'b0));
    for (int e = 0; e < 2; e++) begin
      wr(ADDR_IRQ_ENABLE, e == 1 ? 32'h3 : ZERO_WORD);
      wr(ADDR_COUNTER, 32'h10);
      pm.reload_fall();
      rd(ADDR_COUNTER, q);
      chk(q, 32'h0abc);
      rd(ADDR_FLAGS, q);
      chk(q, e == 1 ? 32'h20 : ZERO_WORD);
      chk({31'h0, irq}, e == 1 ? 32'h1 : ZERO_WORD);
    end
    wr(ADDR_IRQ_ENABLE, ZERO_WORD);
    wr(ADDR_FLAGS, ZERO_WORD);
  endtask

  task automatic t_cmp();
    logic [31:0] q;
    wr(ADDR_CONTROL, ctl(COUNT_EXT, 2'h0, 1'b0));
    wr(ADDR_FUNCTION, 32'h8);
    wr(ADDR_CMP_CAP_1, 32'h5);
    wr(ADDR_COUNTER, 32'h4);
    repeat (3) @(posedge clk_sys_i);
    chk({31'h0, cmp_out[1]}, ZERO_WORD);
    pm.count_pulse();
    chk({31'h0, cmp_out[1]}, 32'h1);
    rd(ADDR_FLAGS, q);
    chk(q, 32'h2);
    wr(ADDR_PORT_LATCH, 32'h2);
    wr(ADDR_CONTROL, ctl(COUNT_EXT, 2'h0, 1'b1));
    wr(ADDR_COUNTER, 32'h4);
    wr(ADDR_PORT_LATCH, ZERO_WORD);
    repeat (3) @(posedge clk_sys_i);
    chk({31'h0, cmp_out[1]}, 32'h1);
    pm.count_pulse();
    chk({31'h0, cmp_out[1]}, ZERO_WORD);
    wr(ADDR_COUNTER, 32'hffff);
    wr(ADDR_PORT_LATCH, 32'h2);
    pm.count_pulse();
    chk({31'h0, cmp_out[1]}, ZERO_WORD);
    wr(ADDR_CONTROL, ZERO_WORD);
  endtask

  task automatic t_cap();
    logic [31:0] q;
    wr(ADDR_FUNCTION, 32'hd1);
    wr(ADDR_COUNTER, 32'h77);
    pm.capture_rise(4'h5);
    rd(ADDR_RELOAD_CAP, q);
    chk(q, 32'h77);
    rd(ADDR_CMP_CAP_2, q);
    chk(q, 32'h77);
    rd(ADDR_CMP_CAP_1, q);
    chk(q, 32'h5);
    wr(ADDR_COUNTER, 32'h99);
    wr(ADDR_CAP_LOW_TRIG, 32'h8);
    rd(ADDR_CMP_CAP_3, q);
    chk(q, 32'h99);
  endtask

  // ----
  // main sequence
  // ----
  initial begin
    reset_i = 1'b1;
    hsel = 1'b1;
    haddr = ZERO_WORD;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = ZERO_WORD;
    repeat (16) @(posedge clk_sys_i);
    reset_i <= 1'b0;
    @(posedge clk_sys_i);
    t_reset();
    t_rate();
    t_gate();
    t_ovf();
    t_pinrl();
    t_cmp();
    t_cap();
    complete_run();
  end
endmodule

// >>> dv/tcc_pin_model.sv
`timescale 1ns/1ps
module tcc_pin_model
  import tcc_pkg::*;
(
  input  wire logic clk_sys_i,
  output tcc_pins_t pins_o
);
  initial begin
    pins_o = '{1'b0, 1'b1, 4'h0};
  end

  task automatic hold(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask

  // two cycles high, six low
  task automatic count_pulse();
    pins_o.ext_count_pin <= 1'b1;
    hold(2);
    pins_o.ext_count_pin <= 1'b0;
    hold(6);
  endtask

  task automatic set_count(input logic v);
    pins_o.ext_count_pin <= v;
    hold(6);
  endtask

  task automatic reload_fall();
    pins_o.ext_reload_pin <= 1'b0;
    hold(4);
    pins_o.ext_reload_pin <= 1'b1;
    hold(6);
  endtask

  task automatic capture_rise(input logic [3:0] m);
    pins_o.capture_pin <= m;
    hold(4);
    pins_o.capture_pin <= 4'h0;
    hold(6);
  endtask
endmodule

// >>> pkg/tcc_pkg.sv
package tcc_pkg;

  // ----------------------------------------------------------------
  // register byte addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CONTROL      = 8'h00;
  localparam logic [7:0] ADDR_FUNCTION     = 8'h04;
  localparam logic [7:0] ADDR_COUNTER      = 8'h08;
  localparam logic [7:0] ADDR_RELOAD_CAP   = 8'h0c;
  localparam logic [7:0] ADDR_CMP_CAP_1    = 8'h10;
  localparam logic [7:0] ADDR_CMP_CAP_2    = 8'h14;
  localparam logic [7:0] ADDR_CMP_CAP_3    = 8'h18;
  localparam logic [7:0] ADDR_IRQ_ENABLE   = 8'h1c;
  localparam logic [7:0] ADDR_FLAGS        = 8'h20;
  localparam logic [7:0] ADDR_PORT_LATCH   = 8'h24;
  localparam logic [7:0] ADDR_CAP_LOW_TRIG = 8'h28;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int CTL_COUNT_LSB    = 0;
  localparam int CTL_METHOD_BIT   = 2;
  localparam int CTL_RELOAD_LSB   = 3;
  localparam int CTL_PRESCALE_BIT = 7;
  localparam int IEN_TIMER_BIT    = 0;
  localparam int IEN_EXTRL_BIT    = 1;
  localparam int IEN_CMP_LSB      = 2;
  localparam int FLG_CMP_LSB      = 0;
  localparam int FLG_OVF_BIT      = 4;
  localparam int FLG_EXTRL_BIT    = 5;
  localparam int NUM_CH           = 4;

  localparam logic [1:0] COUNT_OFF   = 2'h0;
  localparam logic [1:0] COUNT_INT   = 2'h1;
  localparam logic [1:0] COUNT_EXT   = 2'h2;
  localparam logic [1:0] COUNT_GATED = 2'h3;
  localparam logic [1:0] RELOAD_OVF  = 2'h2;
  localparam logic [1:0] RELOAD_PIN  = 2'h3;
  localparam logic [1:0] FN_OFF      = 2'h0;
  localparam logic [1:0] FN_CAP_PIN  = 2'h1;
  localparam logic [1:0] FN_COMPARE  = 2'h2;
  localparam logic [1:0] FN_CAP_SW   = 2'h3;

  localparam logic [4:0] DIV_12     = 5'h0b;
  localparam logic [4:0] DIV_24     = 5'h17;
  localparam logic [15:0] CNT_MAX   = 16'hffff;
  localparam logic [15:0] CNT_RESET = 16'h0000;
  localparam logic [31:0] ZERO_WORD = 32'h0000_0000;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       ext_count_pin;
    logic       ext_reload_pin;
    logic [3:0] capture_pin;
  } tcc_pins_t;

  typedef struct packed {
    logic [1:0] sel;
    logic [1:0] size;
  } tcc_htrans_t;

endpackage
